// *** src/ucs_pkg.sv ***
// Purpose: Shared constants and types for the USB device control and status block.
// Assumes: One 200 MHz clock, register port of eight data bits.
// Notes:   Both ends and the bench use these names.
package ucs_pkg;
	// ------------------------------------------------------------
	// Device register offsets and fields
	// ------------------------------------------------------------
	localparam logic [7:0] FLAGS_OFS   = 8'he8;
	localparam logic [7:0] IEN_OFS     = 8'he9;
	localparam logic [7:0] EP0CTL_OFS  = 8'hea;
	localparam logic [7:0] EP12CTL_OFS = 8'heb;
	localparam logic [7:0] ADDR_OFS    = 8'hee;
	localparam logic [7:0] RESET_VAL   = 8'h00;
	localparam int FN_EN_BIT     = 7;
	localparam int SUSPEND_BIT   = 7;
	localparam int RESERVED_BIT  = 6;
	localparam int RST_PROP_BIT  = 6;
	localparam int BUS_RESET_BIT = 5;
	localparam int EP0_TX_BIT    = 4;
	localparam int EP0_RX_BIT    = 3;
	localparam int EP12_TX_BIT   = 2;
	localparam int EOP_BIT       = 1;
	localparam int WAKEUP_BIT    = 0;
	localparam int TX_EN_BIT     = 5;
	localparam int RX_EN_BIT     = 4;
	localparam logic [7:0] ALL_ONES = 8'hff;
	// ------------------------------------------------------------
	// Link side codes
	// ------------------------------------------------------------
	localparam logic [3:0] EP0  = 4'h0;
	localparam logic [3:0] EP1  = 4'h1;
	localparam logic [3:0] EP2  = 4'h2;
	typedef enum logic [1:0] {PID_IN = 2'b00, PID_OUT = 2'b01, PID_SETUP = 2'b10} ucs_pid_t;
	typedef enum logic [1:0] {REPLY_NAK = 2'b01, REPLY_SEND = 2'b10, REPLY_TAKE = 2'b11} ucs_reply_t;
	// ------------------------------------------------------------
	// Controller registers and timing
	// ------------------------------------------------------------
	localparam logic [7:0] CTL_CFG_OFS  = 8'h00;
	localparam logic [7:0] CTL_CMD_OFS  = 8'h04;
	localparam logic [7:0] CTL_STAT_OFS = 8'h08;
	localparam int CMD_TX0_BIT  = 0;
	localparam int CMD_RX0_BIT  = 1;
	localparam int CMD_TX12_BIT = 2;
	localparam int CLK_MHZ = 200;
	localparam int SUSPEND_IDLE_MS = 3;
	localparam int SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_MS * CLK_MHZ * 1000;
	localparam int IDLE_CNT_W = 20;
endpackage

// *** src/ucs_reg_if.sv ***
// Purpose: Register port joining the controller end to the device end.
// Assumes: Controller holds a request until it sees ack, then drops stb a cycle.
// Notes:   No clocking block; both ends run on clk_sys.
interface ucs_reg_if;
	logic       regStb;
	logic       regWe;
	logic [7:0] regAddr;
	logic [7:0] regWdata;
	logic [7:0] regRdata;
	logic       regAck;
	modport dev (input regStb, input regWe, input regAddr, input regWdata,
		output regRdata, output regAck);
	modport ctl (output regStb, output regWe, output regAddr, output regWdata,
		input regRdata, input regAck);
endinterface

// *** src/ucs_device.sv ***
// What this block does
// - Function enable clear ignores all host tokens.
// - Seven address bits match tokens, reset zero.
// - Enable bits gate their matching status flags.
// - Wakeup interrupt gated, counts only while suspended.
// - Bus reset with propagate enable resets system.
// - Valid bus reset state sets read-only flag.
// - Software suspends after three ms idle.
// - Writing suspend one stops USB clock.
// - Software clears suspend after wakeup flag sets.
// - Activity during suspend sets sticky wakeup flag.
// - Acked endpoint 0 transmit sets its flag.
// - Endpoint 0 transmit flag set NAKs IN.
// - Software clears transmit flag, sets transmit enable.
// - Acked endpoint 0 reception sets its flag.
// - Endpoint 0 receive flag set NAKs OUT.
// - Software clears receive flag after reading, re-enables.
// - Shared endpoint 1/2 flag set on ack.
// - Shared flag set NAKs IN until rearmed.
// - Valid end of packet sets sticky flag.
// - Endpoint 0 transmit enable clear NAKs IN.
//
// Purpose: Device end: address, enable and flag registers plus token replies.
// Assumes: Link events are one-cycle pulses synchronous to clk_sys.
// Notes:   Flags other than bus reset clear by writing zero; writing one leaves them, except suspend.
module ucs_device (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	ucs_reg_if.dev                regPort,
	input  wire logic             busResetDet,
	input  wire logic             eopDet,
	input  wire logic             busActivity,
	input  wire logic             ep0TxAcked,
	input  wire logic             ep0RxAcked,
	input  wire logic             ep12TxAcked,
	input  wire logic             tokValid,
	input  wire ucs_pkg::ucs_pid_t tokPid,
	input  wire logic [6:0]       tokAddr,
	input  wire logic [3:0]       tokEp,
	output logic                  hsValid,
	output ucs_pkg::ucs_reply_t   hsCode,
	output logic                  usbClkRun,
	output logic                  intReset,
	output logic                  irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic                fnEnable;
		logic [6:0]          devAddr;
		logic [7:0]          ien;
		logic [7:0]          flags;
		logic                ep0TxEn;
		logic                ep0RxEn;
		logic                ep12TxEn;
		logic [7:0]          rdData;
		logic                ack;
		logic                intReset;
		logic                irq;
		logic                hsValid;
		ucs_pkg::ucs_reply_t hsCode;
	} ucs_dev_state_t;

	ucs_dev_state_t state_reg;
	ucs_dev_state_t state_next;

	// IN and OUT replies share one form: NAK unless armed and flag clear.
	function automatic ucs_pkg::ucs_reply_t armedReply(input logic en, input logic flag,
		input ucs_pkg::ucs_reply_t go);
		armedReply = (!en || flag) ? ucs_pkg::REPLY_NAK : go;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic access;
		logic [7:0] w;
		access = regPort.regStb && !state_reg.ack;
		w = regPort.regWdata;
		state_next = state_reg;
		state_next.ack = access;
		state_next.hsValid = 1'b0;
		state_next.hsCode = ucs_pkg::REPLY_NAK;
		if (access && regPort.regWe) begin
			if (regPort.regAddr == ucs_pkg::ADDR_OFS) begin
				state_next.fnEnable = w[ucs_pkg::FN_EN_BIT];
				state_next.devAddr = w[6:0];
			end else if (regPort.regAddr == ucs_pkg::IEN_OFS) begin
				state_next.ien = w;
			end else if (regPort.regAddr == ucs_pkg::FLAGS_OFS) begin
				state_next.flags[ucs_pkg::SUSPEND_BIT] = w[ucs_pkg::SUSPEND_BIT];
				state_next.flags[ucs_pkg::EP0_TX_BIT] = state_reg.flags[ucs_pkg::EP0_TX_BIT]
					& w[ucs_pkg::EP0_TX_BIT];
				state_next.flags[ucs_pkg::EP0_RX_BIT] = state_reg.flags[ucs_pkg::EP0_RX_BIT]
					& w[ucs_pkg::EP0_RX_BIT];
				state_next.flags[ucs_pkg::EP12_TX_BIT] = state_reg.flags[ucs_pkg::EP12_TX_BIT]
					& w[ucs_pkg::EP12_TX_BIT];
				state_next.flags[ucs_pkg::EOP_BIT] = state_reg.flags[ucs_pkg::EOP_BIT]
					& w[ucs_pkg::EOP_BIT];
				state_next.flags[ucs_pkg::WAKEUP_BIT] = state_reg.flags[ucs_pkg::WAKEUP_BIT]
					& w[ucs_pkg::WAKEUP_BIT];
			end else if (regPort.regAddr == ucs_pkg::EP0CTL_OFS) begin
				state_next.ep0TxEn = w[ucs_pkg::TX_EN_BIT];
				state_next.ep0RxEn = w[ucs_pkg::RX_EN_BIT];
			end else if (regPort.regAddr == ucs_pkg::EP12CTL_OFS) begin
				state_next.ep12TxEn = w[ucs_pkg::TX_EN_BIT];
			end
		end
		if (access && !regPort.regWe) begin
			if (regPort.regAddr == ucs_pkg::ADDR_OFS) begin
				state_next.rdData = {state_reg.fnEnable, state_reg.devAddr};
			end else if (regPort.regAddr == ucs_pkg::IEN_OFS) begin
				state_next.rdData = state_reg.ien;
			end else if (regPort.regAddr == ucs_pkg::FLAGS_OFS) begin
				state_next.rdData = state_reg.flags;
			end else if (regPort.regAddr == ucs_pkg::EP0CTL_OFS) begin
				state_next.rdData = ucs_pkg::RESET_VAL;
				state_next.rdData[ucs_pkg::TX_EN_BIT] = state_reg.ep0TxEn;
				state_next.rdData[ucs_pkg::RX_EN_BIT] = state_reg.ep0RxEn;
			end else if (regPort.regAddr == ucs_pkg::EP12CTL_OFS) begin
				state_next.rdData = ucs_pkg::RESET_VAL;
				state_next.rdData[ucs_pkg::TX_EN_BIT] = state_reg.ep12TxEn;
			end else begin
				state_next.rdData = ucs_pkg::RESET_VAL;
			end
		end
		// Hardware sets come after the software writes so that a set wins.
		if (busResetDet) begin
			state_next.flags[ucs_pkg::BUS_RESET_BIT] = 1'b1;
		end
		if (ep0TxAcked) begin
			state_next.flags[ucs_pkg::EP0_TX_BIT] = 1'b1;
		end
		if (ep0RxAcked) begin
			state_next.flags[ucs_pkg::EP0_RX_BIT] = 1'b1;
		end
		if (ep12TxAcked) begin
			state_next.flags[ucs_pkg::EP12_TX_BIT] = 1'b1;
		end
		if (eopDet) begin
			state_next.flags[ucs_pkg::EOP_BIT] = 1'b1;
		end
		if (busActivity && state_reg.flags[ucs_pkg::SUSPEND_BIT]) begin
			state_next.flags[ucs_pkg::WAKEUP_BIT] = 1'b1;
		end
		state_next.flags[ucs_pkg::RESERVED_BIT] = 1'b0;
		state_next.intReset = busResetDet && state_reg.ien[ucs_pkg::RST_PROP_BIT];
		// Bit 6 of the flags is reserved zero, so the reset-propagate enable never gates.
		state_next.irq = |(state_next.flags & state_next.ien
			& {7'h7f, state_next.flags[ucs_pkg::SUSPEND_BIT]});
		// Tokens for another address, or any token while disabled, get no reply.
		if (tokValid && state_reg.fnEnable && tokAddr == state_reg.devAddr) begin
			case (tokPid)
				ucs_pkg::PID_IN: begin
					if (tokEp == ucs_pkg::EP0) begin
						state_next.hsValid = 1'b1;
						state_next.hsCode = armedReply(state_reg.ep0TxEn,
							state_reg.flags[ucs_pkg::EP0_TX_BIT], ucs_pkg::REPLY_SEND);
					end else if (tokEp == ucs_pkg::EP1 || tokEp == ucs_pkg::EP2) begin
						state_next.hsValid = 1'b1;
						state_next.hsCode = armedReply(state_reg.ep12TxEn,
							state_reg.flags[ucs_pkg::EP12_TX_BIT], ucs_pkg::REPLY_SEND);
					end
				end
				ucs_pkg::PID_OUT: begin
					if (tokEp == ucs_pkg::EP0) begin
						state_next.hsValid = 1'b1;
						state_next.hsCode = armedReply(state_reg.ep0RxEn,
							state_reg.flags[ucs_pkg::EP0_RX_BIT], ucs_pkg::REPLY_TAKE);
					end
				end
				ucs_pkg::PID_SETUP: begin
					if (tokEp == ucs_pkg::EP0) begin
						state_next.hsValid = 1'b1;
						state_next.hsCode = ucs_pkg::REPLY_TAKE;
					end
				end
				default: begin
					state_next.hsValid = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign regPort.regRdata = state_reg.rdData;
	assign regPort.regAck   = state_reg.ack;
	assign hsValid          = state_reg.hsValid;
	assign hsCode           = state_reg.hsCode;
	assign usbClkRun        = !state_reg.flags[ucs_pkg::SUSPEND_BIT];
	assign intReset         = state_reg.intReset;
	assign irq              = state_reg.irq;
endmodule // ucs_device

// *** src/ucs_controller.sv ***
// Purpose: Controller end: programs the device and services its flags.
// Assumes: Software reaches it over classic Wishbone with 32-bit data.
// Notes:   Polls the flag register whenever no other access is pending.
module ucs_controller #(
	parameter int IDLE_CYCLES = ucs_pkg::SUSPEND_IDLE_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	ucs_reg_if.ctl           regPort,
	input  wire logic        busIdle,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic {CTL_IDLE = 1'b0, CTL_BUSY = 1'b1} ucs_ctl_fsm_t;
	typedef struct packed {
		ucs_ctl_fsm_t                 fsm;
		logic                         stb;
		logic                         we;
		logic [7:0]                   addr;
		logic [7:0]                   wdata;
		logic [7:0]                   cfgAddr;
		logic [7:0]                   cfgIen;
		logic [7:0]                   pend;
		logic                         en0Tx;
		logic                         en0Rx;
		logic                         en12Tx;
		logic                         suspended;
		logic [7:0]                   image;
		logic [ucs_pkg::IDLE_CNT_W-1:0] idleCnt;
		logic                         ack;
		logic [31:0]                  dat;
	} ucs_ctl_state_t;

	localparam int P_ADDR = 0;
	localparam int P_IEN  = 1;
	localparam int P_TX0F = 2;
	localparam int P_RX0F = 3;
	localparam int P_T12F = 4;
	localparam int P_CTL0 = 5;
	localparam int P_CTL1 = 6;
	localparam logic [ucs_pkg::IDLE_CNT_W-1:0] IDLE_LAST =
		ucs_pkg::IDLE_CNT_W'(IDLE_CYCLES - 1);

	ucs_ctl_state_t state_reg;
	ucs_ctl_state_t state_next;

	// A flag write that clears one bit and keeps suspend as given.
	function automatic logic [7:0] clearFlag(input int bitPos, input logic susp);
		clearFlag = ucs_pkg::ALL_ONES;
		clearFlag[bitPos] = 1'b0;
		clearFlag[ucs_pkg::SUSPEND_BIT] = susp;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic wbAccess;
		logic wbWrite;
		wbAccess = cyc_i && stb_i && !state_reg.ack;
		// A write lands at the edge where the master sees ack, as classic Wishbone has it.
		wbWrite = cyc_i && stb_i && we_i && state_reg.ack;
		state_next = state_reg;
		state_next.ack = wbAccess;
		if (busIdle && !state_reg.suspended) begin
			if (state_reg.idleCnt != IDLE_LAST) begin
				state_next.idleCnt = state_reg.idleCnt + 1'b1;
			end
		end else begin
			state_next.idleCnt = '0;
		end
		case (state_reg.fsm)
			CTL_IDLE: begin
				state_next.fsm = CTL_BUSY;
				state_next.stb = 1'b1;
				state_next.we = 1'b1;
				state_next.addr = ucs_pkg::FLAGS_OFS;
				if (state_reg.image[ucs_pkg::WAKEUP_BIT] && state_reg.suspended) begin
					state_next.wdata = clearFlag(ucs_pkg::WAKEUP_BIT, 1'b0);
					state_next.suspended = 1'b0;
					state_next.image[ucs_pkg::WAKEUP_BIT] = 1'b0;
				end else if (state_reg.idleCnt == IDLE_LAST && !state_reg.suspended) begin
					state_next.wdata = ucs_pkg::ALL_ONES;
					state_next.suspended = 1'b1;
					state_next.idleCnt = '0;
				end else if (state_reg.pend[P_ADDR]) begin
					state_next.addr = ucs_pkg::ADDR_OFS;
					state_next.wdata = state_reg.cfgAddr;
					state_next.pend[P_ADDR] = 1'b0;
				end else if (state_reg.pend[P_IEN]) begin
					state_next.addr = ucs_pkg::IEN_OFS;
					state_next.wdata = state_reg.cfgIen;
					state_next.pend[P_IEN] = 1'b0;
				end else if (state_reg.pend[P_TX0F]) begin
					state_next.wdata = clearFlag(ucs_pkg::EP0_TX_BIT, state_reg.suspended);
					state_next.pend[P_TX0F] = 1'b0;
					state_next.pend[P_CTL0] = 1'b1;
					state_next.en0Tx = 1'b1;
				end else if (state_reg.pend[P_RX0F]) begin
					state_next.wdata = clearFlag(ucs_pkg::EP0_RX_BIT, state_reg.suspended);
					state_next.pend[P_RX0F] = 1'b0;
					state_next.pend[P_CTL0] = 1'b1;
					state_next.en0Rx = 1'b1;
				end else if (state_reg.pend[P_T12F]) begin
					state_next.wdata = clearFlag(ucs_pkg::EP12_TX_BIT, state_reg.suspended);
					state_next.pend[P_T12F] = 1'b0;
					state_next.pend[P_CTL1] = 1'b1;
					state_next.en12Tx = 1'b1;
				end else if (state_reg.pend[P_CTL0]) begin
					state_next.addr = ucs_pkg::EP0CTL_OFS;
					state_next.wdata = ucs_pkg::RESET_VAL;
					state_next.wdata[ucs_pkg::TX_EN_BIT] = state_reg.en0Tx;
					state_next.wdata[ucs_pkg::RX_EN_BIT] = state_reg.en0Rx;
					state_next.pend[P_CTL0] = 1'b0;
				end else if (state_reg.pend[P_CTL1]) begin
					state_next.addr = ucs_pkg::EP12CTL_OFS;
					state_next.wdata = ucs_pkg::RESET_VAL;
					state_next.wdata[ucs_pkg::TX_EN_BIT] = state_reg.en12Tx;
					state_next.pend[P_CTL1] = 1'b0;
				end else begin
					state_next.we = 1'b0;
					state_next.wdata = ucs_pkg::RESET_VAL;
				end
			end
			CTL_BUSY: begin
				if (regPort.regAck) begin
					state_next.fsm = CTL_IDLE;
					state_next.stb = 1'b0;
					if (!state_reg.we) begin
						state_next.image = regPort.regRdata;
					end
				end
			end
			default: begin
				state_next.fsm = CTL_IDLE;
			end
		endcase
		// Software commands land after the issue logic so a new order is never lost.
		if (wbWrite) begin
			if (adr_i == ucs_pkg::CTL_CFG_OFS) begin
				if (sel_i[0]) begin
					state_next.cfgAddr = dat_i[7:0];
					state_next.pend[P_ADDR] = 1'b1;
				end
				if (sel_i[1]) begin
					state_next.cfgIen = dat_i[15:8];
					state_next.pend[P_IEN] = 1'b1;
				end
			end else if (adr_i == ucs_pkg::CTL_CMD_OFS && sel_i[0]) begin
				if (dat_i[ucs_pkg::CMD_TX0_BIT]) begin
					state_next.pend[P_TX0F] = 1'b1;
				end
				if (dat_i[ucs_pkg::CMD_RX0_BIT]) begin
					state_next.pend[P_RX0F] = 1'b1;
				end
				if (dat_i[ucs_pkg::CMD_TX12_BIT]) begin
					state_next.pend[P_T12F] = 1'b1;
				end
			end
		end
		if (wbAccess && !we_i) begin
			if (adr_i == ucs_pkg::CTL_CFG_OFS) begin
				state_next.dat = {16'h0000, state_reg.cfgIen, state_reg.cfgAddr};
			end else if (adr_i == ucs_pkg::CTL_CMD_OFS) begin
				state_next.dat = {24'h000000, state_reg.pend};
			end else if (adr_i == ucs_pkg::CTL_STAT_OFS) begin
				state_next.dat = {22'h000000, state_reg.suspended, |state_reg.pend,
					state_reg.image};
			end else begin
				state_next.dat = 32'h00000000;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign regPort.regStb   = state_reg.stb;
	assign regPort.regWe    = state_reg.we;
	assign regPort.regAddr  = state_reg.addr;
	assign regPort.regWdata = state_reg.wdata;
	assign dat_o            = state_reg.dat;
	assign ack_o            = state_reg.ack;
endmodule // ucs_controller

// *** verif/ucs_asserts.sv ***
// Purpose: Concurrent checks on the register port and the link replies.
// Assumes: One clock; a device write lands at the edge that takes the request.
// Notes:   Small shadows follow only the registers these checks depend on.
module ucs_asserts (
	input wire logic                clk_sys,
	input wire logic                rst,
	input wire logic                regStb,
	input wire logic                regWe,
	input wire logic [7:0]          regAddr,
	input wire logic [7:0]          regWdata,
	input wire logic                regAck,
	input wire logic                tokValid,
	input wire ucs_pkg::ucs_pid_t   tokPid,
	input wire logic [6:0]          tokAddr,
	input wire logic [3:0]          tokEp,
	input wire logic                ep0TxAcked,
	input wire logic                busResetDet,
	input wire logic                hsValid,
	input wire ucs_pkg::ucs_reply_t hsCode,
	input wire logic                usbClkRun,
	input wire logic                intReset
);
	// ------------------------------------------------------------
	// Shadow registers
	// ------------------------------------------------------------
	logic [7:0] addrReg;
	logic [7:0] ienReg;
	logic       txFlagReg;
	logic       wrDone;
	assign wrDone = regStb && !regAck && regWe;
	// A hardware set beats a clear in the same cycle, as in the device.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			addrReg <= 8'h00;
			ienReg <= 8'h00;
			txFlagReg <= 1'b0;
		end else begin
			if (wrDone && regAddr == ucs_pkg::ADDR_OFS) begin
				addrReg <= regWdata;
			end
			if (wrDone && regAddr == ucs_pkg::IEN_OFS) begin
				ienReg <= regWdata;
			end
			if (ep0TxAcked) begin
				txFlagReg <= 1'b1;
			end else if (wrDone && regAddr == ucs_pkg::FLAGS_OFS && !regWdata[4]) begin
				txFlagReg <= 1'b0;
			end
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	ack_single_a: assert property (regAck |=> !regAck)
		else $error("register ack held longer than one cycle");
	ack_prompt_a: assert property (regStb && !regAck |=> regAck)
		else $error("register ack late");
	ack_cause_a: assert property (regAck |-> $past(regStb))
		else $error("register ack without request");
	reply_cause_a: assert property (hsValid |-> $past(tokValid))
		else $error("reply without token");
	fn_off_a: assert property (tokValid && !addrReg[7] |=> !hsValid)
		else $error("reply while function disabled");
	addr_match_a: assert property (tokValid && tokAddr != addrReg[6:0] |=> !hsValid)
		else $error("reply to a foreign address");
	ep0_nak_a: assert property (tokValid && tokPid == ucs_pkg::PID_IN
		&& tokEp == ucs_pkg::EP0 && txFlagReg |=> hsCode == ucs_pkg::REPLY_NAK)
		else $error("endpoint 0 sent data while its flag was set");
	reset_prop_a: assert property (intReset == $past(busResetDet && ienReg[6]))
		else $error("internal reset does not follow bus reset");
	clk_stop_a: assert property (wrDone && regAddr == ucs_pkg::FLAGS_OFS
		&& regWdata[7] |-> ##[1:2] !usbClkRun)
		else $error("usb clock still runs after suspend");
	cover property (tokValid && tokPid == ucs_pkg::PID_IN && txFlagReg);
	cover property (intReset);
	cover property (!usbClkRun ##1 usbClkRun);
endmodule // ucs_asserts

// *** verif/usb_device_control_status_bench.sv ***
// Purpose: Self-checking bench joining controller and device ends.
// Assumes: Idle count shortened to 50 cycles so suspend is reached quickly.
// Notes:   Expected flags, enables and replies are kept in a bench model.
module usb_device_control_status_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TIMEOUT_CYCLES = 40000;
	logic clk_sys, rst, busIdle, wbCyc, wbStb, wbWe, wbAck, tokValid;
	logic hsValid, usbClkRun, intReset, irq;
	logic [7:0] wbAdr, mAddr, mIen, mFlags;
	logic [3:0] wbSel, tokEp;
	logic [31:0] wbDatW, wbDatR, rd, r, seed;
	logic [5:0] ev;
	logic [6:0] tokAddr;
	logic [2:0] mEn;
	ucs_pkg::ucs_pid_t tokPid;
	ucs_pkg::ucs_reply_t hsCode;
	int nFail, samplesChecked, cycles;
	ucs_reg_if regBus ();
	ucs_device u_ucs_device (.clk_sys(clk_sys), .rst(rst), .regPort(regBus.dev),
		.busResetDet(ev[0]), .eopDet(ev[1]), .busActivity(ev[2]), .ep0TxAcked(ev[3]),
		.ep0RxAcked(ev[4]), .ep12TxAcked(ev[5]), .tokValid(tokValid), .tokPid(tokPid),
		.tokAddr(tokAddr), .tokEp(tokEp), .hsValid(hsValid), .hsCode(hsCode),
		.usbClkRun(usbClkRun), .intReset(intReset), .irq(irq));
	ucs_controller #(.IDLE_CYCLES(50)) u_ucs_controller (.clk_sys(clk_sys), .rst(rst),
		.regPort(regBus.ctl), .busIdle(busIdle), .cyc_i(wbCyc), .stb_i(wbStb), .we_i(wbWe),
		.adr_i(wbAdr), .sel_i(wbSel), .dat_i(wbDatW), .dat_o(wbDatR), .ack_o(wbAck));
	ucs_asserts u_ucs_asserts (.clk_sys(clk_sys), .rst(rst), .regStb(regBus.regStb),
		.regWe(regBus.regWe), .regAddr(regBus.regAddr), .regWdata(regBus.regWdata),
		.regAck(regBus.regAck), .tokValid(tokValid), .tokPid(tokPid), .tokAddr(tokAddr),
		.tokEp(tokEp), .ep0TxAcked(ev[3]), .busResetDet(ev[0]), .hsValid(hsValid),
		.hsCode(hsCode), .usbClkRun(usbClkRun), .intReset(intReset));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic expIrq();
		return |(mFlags & mIen & {2'b10, 5'h1f, mFlags[7]});
	endfunction
	function automatic logic [2:0] expReply(input ucs_pkg::ucs_pid_t p, input logic [6:0] a,
		input logic [3:0] e);
		logic ok;
		ok = mEn[0] && !mFlags[4];
		if (!mAddr[7] || a !== mAddr[6:0] || e > 4'h2 || (e != 4'h0 && p != ucs_pkg::PID_IN))
			return {1'b0, ucs_pkg::REPLY_NAK};
		if (p == ucs_pkg::PID_IN && e != 4'h0) ok = mEn[2] && !mFlags[2];
		if (p == ucs_pkg::PID_OUT) ok = mEn[1] && !mFlags[3];
		if (p == ucs_pkg::PID_SETUP) ok = 1'b1;
		if (!ok) return {1'b1, ucs_pkg::REPLY_NAK};
		return {1'b1, p == ucs_pkg::PID_IN ? ucs_pkg::REPLY_SEND : ucs_pkg::REPLY_TAKE};
	endfunction
	task automatic reportAndStop();
		$display("checks=%0d mismatches=%0d", samplesChecked, nFail);
		if (nFail == 0 && samplesChecked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			nFail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		@(posedge clk_sys);
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} <= {2'b11, we, a, s, d};
		do @(posedge clk_sys); while (wbAck !== 1'b1);
		rd = wbDatR;
		{wbCyc, wbStb, wbWe} <= 3'b000;
	endtask
	// Polled flags lag the device by a poll round, so a few reads follow idle.
	task automatic settle();
		do wb(1'b0, ucs_pkg::CTL_STAT_OFS, 4'hf, 32'h0); while (rd[8] !== 1'b0);
		repeat (3) wb(1'b0, ucs_pkg::CTL_STAT_OFS, 4'hf, 32'h0);
		cmp(rd[7:0], mFlags);
		cmp({7'h0, rd[9]}, {7'h0, mFlags[7]});
		cmp({7'h0, irq}, {7'h0, expIrq()});
	endtask
	task automatic cfg(input logic [7:0] a, input logic [7:0] ie);
		wb(1'b1, ucs_pkg::CTL_CFG_OFS, 4'h3, {16'h0, ie, a});
		mAddr = a;
		mIen = ie;
		settle();
	endtask
	task automatic cmd(input logic [2:0] c);
		wb(1'b1, ucs_pkg::CTL_CMD_OFS, 4'h1, {29'h0, c});
		mEn = mEn | c;
		mFlags = mFlags & ~{3'h0, c[0], c[1], c[2], 2'h0};
		settle();
	endtask
	task automatic pulse(input logic [5:0] m);
		@(posedge clk_sys);
		ev <= m;
		@(posedge clk_sys);
		ev <= 6'h00;
		@(posedge clk_sys);
		cmp({7'h0, intReset}, {7'h0, m[0] & mIen[6]});
		mFlags = mFlags | {2'b0, m[0], m[3], m[4], m[5], m[1], m[2] & mFlags[7]};
	endtask
	task automatic tok(input ucs_pkg::ucs_pid_t p, input logic [6:0] a, input logic [3:0] e);
		logic [2:0] x;
		x = expReply(p, a, e);
		@(posedge clk_sys);
		{tokValid, tokPid, tokAddr, tokEp} <= {1'b1, p, a, e};
		@(posedge clk_sys);
		tokValid <= 1'b0;
		@(posedge clk_sys);
		cmp({5'h0, hsValid, hsCode}, {5'h0, x});
	endtask
	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles = cycles + 1;
		if (cycles == TIMEOUT_CYCLES) begin
			nFail++;
			reportAndStop();
		end
	end
	initial begin
		{rst, busIdle, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = {1'b1, 48'h0};
		{ev, tokValid, tokAddr, tokEp, mAddr, mIen, mFlags, mEn} = '0;
		tokPid = ucs_pkg::PID_IN;
		{nFail, samplesChecked, cycles} = '0;
		seed = 32'd38526;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		cmp({4'h0, hsValid, hsCode, intReset}, 8'h00);
		cmp({6'h0, usbClkRun, irq}, 8'h02);
		wb(1'b0, 8'h0c, 4'hf, 32'h0);
		cmp(rd[7:0], 8'h00);
		settle();
		tok(ucs_pkg::PID_SETUP, 7'h00, ucs_pkg::EP0);
		cfg(8'hab, 8'h00);
		for (int i = 0; i < 2; i++) begin
			for (int p = 0; p < 3; p++) tok(ucs_pkg::ucs_pid_t'(p), 7'h2b, 4'(p));
			tok(ucs_pkg::PID_SETUP, 7'h2a, ucs_pkg::EP0);
			if (i == 0) cmd(3'h7);
		end
		pulse(6'h3a);
		settle();
		for (int p = 0; p < 4; p++) tok(ucs_pkg::ucs_pid_t'(p % 2), 7'h2b, 4'(p & 2));
		for (int b = 0; b < 8; b++) cfg(8'hab, 8'h01 << b);
		pulse(6'h01);
		settle();
		cfg(8'hab, 8'hbf);
		for (int i = 0; i < 80; i++) begin
			r = xs();
			if (r[1:0] == 2'd0) pulse(r[7:2]);
			else if (r[1:0] == 2'd1) cmd(r[4:2]);
			else tok(r[3:2] == 2'b11 ? ucs_pkg::PID_IN : ucs_pkg::ucs_pid_t'(r[3:2]),
				r[4] ? 7'h2b : r[11:5], {2'b0, r[13:12]});
		end
		settle();
		cfg(8'hab, 8'h81);
		busIdle <= 1'b1;
		do @(posedge clk_sys); while (usbClkRun !== 1'b0);
		busIdle <= 1'b0;
		mFlags = mFlags | 8'h80;
		settle();
		pulse(6'h04);
		do @(posedge clk_sys); while (usbClkRun !== 1'b1);
		mFlags = mFlags & 8'h7e;
		settle();
		reportAndStop();
	end
endmodule // usb_device_control_status_bench
